// *** hw/adcss_cgl_mem.sv ***
// Channel list memory: one channel number per entry, registered read.
// Assumes the writer only loads it while the sequencer is idle.
`timescale 1ns/1ps
module adcss_cgl_mem (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Write port
	input wire logic we,
	input wire logic [adcss_pkg::IDX_W-1:0] waddr,
	input wire logic [adcss_pkg::CHAN_W-1:0] wdata,
	// Read port
	input wire logic [adcss_pkg::IDX_W-1:0] raddr,
	output logic [adcss_pkg::CHAN_W-1:0] rdata
);

	logic [adcss_pkg::CHAN_W-1:0] mem_reg [adcss_pkg::LIST_DEPTH];

	// ------------------------------------------------------------
	// Storage, one entry per generate step
	// ------------------------------------------------------------
	for (genvar i = 0; i < adcss_pkg::LIST_DEPTH; i++) begin : g_ent
		// Entries clear at reset so an unloaded list reads channel zero.
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				mem_reg[i] <= '0;
			end else if (we && waddr == adcss_pkg::IDX_W'(i)) begin
				mem_reg[i] <= wdata;
			end
		end
	end

	// Read data from a register, one cycle behind the address.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= '0;
		end else begin
			rdata <= mem_reg[raddr];
		end
	end

endmodule : adcss_cgl_mem

// *** hw/adcss_pkg.sv ***
// Package of the analog-input scan sequencer: constants, states and carriers.
// Assumes a 40 MHz system clock and a converter that answers each start with one done pulse.
package adcss_pkg;

	// ------------------------------------------------------------
	// Clocking and time base
	// ------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int BASE_HZ = 12_000_000;
	localparam logic [5:0] ACC_STEP = 6'(BASE_HZ / 1_000_000);
	localparam logic [5:0] ACC_WRAP = 6'(CLK_HZ / 1_000_000);

	// ------------------------------------------------------------
	// Retrigger interval limits, in base ticks
	// ------------------------------------------------------------
	localparam int RT_MAX_HZ_FAST = 100_000;
	localparam int RT_MAX_HZ_SLOW = 50_000;
	// The least rate of 0.75 Hz is written as 3/4 to stay in integers.
	localparam logic [23:0] RT_DIV_MAX = 24'(BASE_HZ * 4 / 3);
	localparam logic [23:0] RT_DIV_MIN_FAST = 24'(BASE_HZ / RT_MAX_HZ_FAST);
	localparam logic [23:0] RT_DIV_MIN_SLOW = 24'(BASE_HZ / RT_MAX_HZ_SLOW);

	// ------------------------------------------------------------
	// Field widths and channel list
	// ------------------------------------------------------------
	localparam int CNT_W = 24;
	localparam int CHAN_W = 5;
	localparam int IDX_W = 4;
	localparam int LIST_DEPTH = 16;
	localparam int DATA_W = 16;

	// ------------------------------------------------------------
	// Retrigger sources
	// ------------------------------------------------------------
	localparam logic [1:0] RT_SRC_SW = 2'h0;
	localparam logic [1:0] RT_SRC_EXT = 2'h1;
	localparam logic [1:0] RT_SRC_INT = 2'h2;

	// Gray coded along idle, armed, run, convert, wait.
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ARMED = 3'h1,
		ST_RUN = 3'h3,
		ST_CONV = 3'h2,
		ST_WAIT_RT = 3'h6,
		ST_DRAIN = 3'h7,
		ST_SINGLE = 3'h5
	} adcss_state_t;

	// Converter request carrier.
	typedef struct packed {
		logic start;
		logic [CHAN_W-1:0] chan;
	} adcss_conv_t;

	// Result carrier toward the host.
	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] data;
		logic [IDX_W-1:0] entry;
		logic single;
	} adcss_sample_t;

	// Whole state of the sequencer.
	typedef struct packed {
		adcss_state_t fsm;
		logic [IDX_W-1:0] idx;
		logic [5:0] acc;
		logic [CNT_W-1:0] sclk_cnt;
		logic [CNT_W-1:0] rt_cnt;
		logic rt_pend;
		logic ext_trig_q;
		logic ext_sclk_q;
		adcss_conv_t conv;
		adcss_sample_t smp;
		logic flush;
		logic done;
	} adcss_regs_t;

endpackage : adcss_pkg

// *** hw/adcss_sequencer.sv ***
// Analog-input scan sequencer: single reads, paced scans and retriggered scans.
// Assumes synchronous host strobes and a converter answering each start with CONV_DONE.
`timescale 1ns/1ps
module adcss_sequencer (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Host commands
	input wire logic SINGLE_REQ,
	input wire logic [adcss_pkg::CHAN_W-1:0] SINGLE_CHAN,
	input wire logic START,
	input wire logic SW_RETRIG,
	input wire logic STOP_ORDERLY,
	input wire logic STOP_ABRUPT,
	input wire logic BUF_FULL,
	// Host configuration
	input wire logic INIT_TRIG_EXT,
	input wire logic TRIGGERED_EN,
	input wire logic [1:0] RETRIG_SRC,
	input wire logic [adcss_pkg::CNT_W-1:0] RETRIG_DIV,
	input wire logic SLOW_VARIANT,
	input wire logic SCLK_EXT_SEL,
	input wire logic [adcss_pkg::CNT_W-1:0] SCLK_DIV,
	// Channel list loading
	input wire logic CGL_WE,
	input wire logic [adcss_pkg::IDX_W-1:0] CGL_ADDR,
	input wire logic [adcss_pkg::CHAN_W-1:0] CGL_DATA,
	input wire logic [adcss_pkg::IDX_W-1:0] CGL_LAST,
	// External pins
	input wire logic EXT_TRIG,
	input wire logic EXT_SCLK,
	// Converter
	output adcss_pkg::adcss_conv_t CONV,
	input wire logic CONV_DONE,
	input wire logic [adcss_pkg::DATA_W-1:0] CONV_DATA,
	// Results and status
	output adcss_pkg::adcss_sample_t SAMPLE,
	output logic FLUSH,
	output logic DONE,
	output logic BUSY
);

	adcss_pkg::adcss_regs_t s_reg;
	adcss_pkg::adcss_regs_t s_next;
	logic [adcss_pkg::CHAN_W-1:0] list_chan;
	logic base_tick;
	logic sclk_tick;
	logic ext_edge;
	logic scan_on;
	logic last_entry;
	logic rt_hit;
	logic [6:0] acc_sum;
	logic [adcss_pkg::CNT_W-1:0] rt_div_eff;
	logic [adcss_pkg::CNT_W-1:0] rt_min;
	logic [adcss_pkg::CNT_W-1:0] sclk_top;

	// ------------------------------------------------------------
	// Channel list
	// ------------------------------------------------------------
	// The address is the next index, so the read data always match idx.
	adcss_cgl_mem u_cgl (
		.clk(CLK),
		.reset_n(RESET_N),
		.we(CGL_WE),
		.waddr(CGL_ADDR),
		.wdata(CGL_DATA),
		.raddr(s_next.idx),
		.rdata(list_chan)
	);

	// ------------------------------------------------------------
	// Time base, pacing and edge detection
	// ------------------------------------------------------------
	// Accumulating steps of 12 and wrapping at 40 gives an exact 12 MHz average enable.
	assign acc_sum = {1'b0, s_reg.acc} + {1'b0, adcss_pkg::ACC_STEP};
	assign base_tick = acc_sum >= {1'b0, adcss_pkg::ACC_WRAP};
	assign sclk_top = (SCLK_DIV == '0) ? '0 : SCLK_DIV - 24'h000001;
	// Conversions start on the rising edge of the chosen sample clock.
	assign ext_edge = EXT_TRIG && !s_reg.ext_trig_q;
	assign sclk_tick = SCLK_EXT_SEL ? (EXT_SCLK && !s_reg.ext_sclk_q) :
		(base_tick && s_reg.sclk_cnt >= sclk_top);
	// The retrigger interval is clamped into the supported rate range.
	assign rt_min = SLOW_VARIANT ? adcss_pkg::RT_DIV_MIN_SLOW : adcss_pkg::RT_DIV_MIN_FAST;
	assign rt_div_eff = (RETRIG_DIV < rt_min) ? rt_min :
		(RETRIG_DIV > adcss_pkg::RT_DIV_MAX) ? adcss_pkg::RT_DIV_MAX : RETRIG_DIV;
	assign rt_hit = base_tick && s_reg.rt_cnt >= rt_div_eff - 24'h000001;
	assign scan_on = s_reg.fsm inside {adcss_pkg::ST_RUN, adcss_pkg::ST_CONV,
		adcss_pkg::ST_WAIT_RT, adcss_pkg::ST_DRAIN};
	assign last_entry = s_reg.idx == CGL_LAST;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.conv.start = 1'b0;
		s_next.smp.valid = 1'b0;
		s_next.flush = 1'b0;
		s_next.done = 1'b0;
		s_next.acc = base_tick ? 6'(acc_sum - {1'b0, adcss_pkg::ACC_WRAP}) : 6'(acc_sum);
		s_next.ext_trig_q = EXT_TRIG;
		s_next.ext_sclk_q = EXT_SCLK;
		// The pacing counter free-runs during a scan and rests at zero otherwise.
		if (!scan_on) begin
			s_next.sclk_cnt = '0;
		end else if (base_tick) begin
			s_next.sclk_cnt = (s_reg.sclk_cnt >= sclk_top) ? '0 : s_reg.sclk_cnt + 24'h000001;
		end
		// Internal retrigger interval free-runs from the start of the scan, not of each pass.
		if (scan_on && base_tick) begin
			s_next.rt_cnt = rt_hit ? '0 : s_reg.rt_cnt + 24'h000001;
		end
		// Software or internal retriggers seen mid-pass are held for its end.
		if (scan_on && TRIGGERED_EN && ((RETRIG_SRC == adcss_pkg::RT_SRC_SW && SW_RETRIG) ||
				(RETRIG_SRC == adcss_pkg::RT_SRC_INT && rt_hit))) begin
			s_next.rt_pend = 1'b1;
		end
		case (s_reg.fsm)
			adcss_pkg::ST_IDLE: begin
				s_next.idx = '0;
				s_next.rt_pend = 1'b0;
				s_next.rt_cnt = '0;
				if (SINGLE_REQ) begin
					s_next.conv.start = 1'b1;
					s_next.conv.chan = SINGLE_CHAN;
					s_next.fsm = adcss_pkg::ST_SINGLE;
				end else if (START) begin
					s_next.fsm = INIT_TRIG_EXT ? adcss_pkg::ST_ARMED : adcss_pkg::ST_RUN;
				end
			end
			adcss_pkg::ST_ARMED: begin
				if (STOP_ABRUPT || STOP_ORDERLY) begin
					s_next.fsm = adcss_pkg::ST_IDLE;
					s_next.done = 1'b1;
				end else if (ext_edge) begin
					s_next.fsm = adcss_pkg::ST_RUN;
				end
			end
			adcss_pkg::ST_RUN: begin
				if (STOP_ABRUPT) begin
					s_next.fsm = adcss_pkg::ST_IDLE;
					s_next.flush = 1'b1;
				end else if (STOP_ORDERLY || BUF_FULL) begin
					s_next.fsm = adcss_pkg::ST_IDLE;
					s_next.done = 1'b1;
				end else if (sclk_tick) begin
					s_next.conv.start = 1'b1;
					s_next.conv.chan = list_chan;
					s_next.fsm = adcss_pkg::ST_CONV;
				end
			end
			adcss_pkg::ST_CONV, adcss_pkg::ST_DRAIN: begin
				if (STOP_ABRUPT) begin
					s_next.fsm = adcss_pkg::ST_IDLE;
					s_next.flush = 1'b1;
				end else if (CONV_DONE) begin
					s_next.smp.valid = 1'b1;
					s_next.smp.data = CONV_DATA;
					s_next.smp.entry = s_reg.idx;
					s_next.smp.single = 1'b0;
					s_next.idx = last_entry ? '0 : s_reg.idx + 4'h1;
					if (s_reg.fsm == adcss_pkg::ST_DRAIN || STOP_ORDERLY || BUF_FULL) begin
						s_next.fsm = adcss_pkg::ST_IDLE;
						s_next.done = 1'b1;
					end else if (last_entry && TRIGGERED_EN) begin
						// A pass is over; a held retrigger starts the next one.
						// A retrigger that lands on the closing edge still counts: set wins.
						s_next.fsm = s_next.rt_pend ? adcss_pkg::ST_RUN : adcss_pkg::ST_WAIT_RT;
						s_next.rt_pend = 1'b0;
					end else begin
						s_next.fsm = adcss_pkg::ST_RUN;
					end
				end else if (STOP_ORDERLY || BUF_FULL) begin
					s_next.fsm = adcss_pkg::ST_DRAIN;
				end
			end
			adcss_pkg::ST_WAIT_RT: begin
				if (STOP_ABRUPT) begin
					s_next.fsm = adcss_pkg::ST_IDLE;
					s_next.flush = 1'b1;
				end else if (STOP_ORDERLY || BUF_FULL) begin
					s_next.fsm = adcss_pkg::ST_IDLE;
					s_next.done = 1'b1;
				end else if (s_reg.rt_pend || s_next.rt_pend ||
						(RETRIG_SRC == adcss_pkg::RT_SRC_EXT && ext_edge)) begin
					s_next.fsm = adcss_pkg::ST_RUN;
					s_next.rt_pend = 1'b0;
				end
			end
			adcss_pkg::ST_SINGLE: begin
				// Stops are not looked at here; the read always runs to its end.
				if (CONV_DONE) begin
					s_next.smp.valid = 1'b1;
					s_next.smp.data = CONV_DATA;
					s_next.smp.entry = '0;
					s_next.smp.single = 1'b1;
					s_next.fsm = adcss_pkg::ST_IDLE;
				end
			end
			default: begin
				s_next.fsm = adcss_pkg::ST_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register.
	assign CONV = s_reg.conv;
	assign SAMPLE = s_reg.smp;
	assign FLUSH = s_reg.flush;
	assign DONE = s_reg.done;
	assign BUSY = s_reg.fsm != adcss_pkg::ST_IDLE;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	single_start_a: assert property (
		s_reg.fsm == adcss_pkg::ST_IDLE && SINGLE_REQ |=>
			CONV.start && CONV.chan == $past(SINGLE_CHAN) && s_reg.fsm == adcss_pkg::ST_SINGLE)
		else $error("Single read did not start its conversion.");
	single_nostop_a: assert property (
		s_reg.fsm == adcss_pkg::ST_SINGLE && !CONV_DONE |=> s_reg.fsm == adcss_pkg::ST_SINGLE)
		else $error("Single read left before its result.");
	orderly_drain_a: assert property (
		s_reg.fsm == adcss_pkg::ST_CONV && STOP_ORDERLY && !STOP_ABRUPT && !CONV_DONE |=>
			s_reg.fsm == adcss_pkg::ST_DRAIN)
		else $error("Orderly stop did not drain the conversion.");
	abrupt_flush_a: assert property (
		scan_on && STOP_ABRUPT |=> FLUSH && !SAMPLE.valid && s_reg.fsm == adcss_pkg::ST_IDLE)
		else $error("Abrupt stop did not discard at once.");
	wrap_list_a: assert property (
		s_reg.fsm == adcss_pkg::ST_CONV && CONV_DONE && last_entry && !TRIGGERED_EN &&
			!STOP_ABRUPT && !STOP_ORDERLY && !BUF_FULL |=>
			s_reg.fsm == adcss_pkg::ST_RUN && s_reg.idx == '0 && SAMPLE.valid)
		else $error("Paced scan did not wrap to the first entry.");
	tick_paced_a: assert property (
		s_reg.fsm == adcss_pkg::ST_RUN && !STOP_ABRUPT && !STOP_ORDERLY && !BUF_FULL |=>
			CONV.start == $past(sclk_tick))
		else $error("Conversion start not tied to the sample clock.");
	rt_range_a: assert property (
		rt_div_eff >= rt_min && rt_div_eff <= adcss_pkg::RT_DIV_MAX)
		else $error("Retrigger interval out of range.");
	ext_ignored_a: assert property (
		s_reg.fsm == adcss_pkg::ST_RUN && RETRIG_SRC == adcss_pkg::RT_SRC_EXT && !s_reg.rt_pend
			|=> !s_reg.rt_pend)
		else $error("External edge was held during a pass.");
	retrig_restart_a: assert property (
		s_reg.fsm == adcss_pkg::ST_CONV && CONV_DONE && last_entry && TRIGGERED_EN &&
			s_reg.rt_pend && !STOP_ABRUPT && !STOP_ORDERLY && !BUF_FULL |=>
			s_reg.fsm == adcss_pkg::ST_RUN && s_reg.idx == '0)
		else $error("Held retrigger did not restart the pass.");
	sw_start_a: assert property (
		s_reg.fsm == adcss_pkg::ST_IDLE && START && !SINGLE_REQ && !INIT_TRIG_EXT |=>
			s_reg.fsm == adcss_pkg::ST_RUN)
		else $error("Software trigger did not start the scan.");

	single_done_c: cover property (s_reg.fsm == adcss_pkg::ST_SINGLE ##1 SAMPLE.single);
	wrap_c: cover property (s_reg.fsm == adcss_pkg::ST_CONV && CONV_DONE && last_entry);
	wait_rt_c: cover property (s_reg.fsm == adcss_pkg::ST_WAIT_RT ##1
		s_reg.fsm == adcss_pkg::ST_RUN);
	abrupt_c: cover property (FLUSH);

endmodule : adcss_sequencer

// *** verif/adcss_conv_model.sv ***
// Behavioural converter facing the sequencer: answers each start with one done pulse.
// Assumes starts never overlap; a start while busy restarts the conversion.
`timescale 1ns/1ps
module adcss_conv_model #(
	parameter int LAT = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Converter request and answer
	input adcss_pkg::adcss_conv_t conv,
	output logic done,
	output logic [adcss_pkg::DATA_W-1:0] data
);
	int cnt;
	logic [adcss_pkg::CHAN_W-1:0] ch;

	// Data is valid only with done; otherwise the bus toggles so a stale value never passes.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt = 0;
			done <= 1'b0;
			data <= 16'h0000;
		end else begin
			done <= 1'b0;
			data <= ~data;
			if (conv.start) begin
				cnt = LAT;
				ch = conv.chan;
			end else if (cnt > 1) begin
				cnt = cnt - 1;
			end else if (cnt == 1) begin
				cnt = 0;
				done <= 1'b1;
				data <= {11'h2D3, ch};
			end
		end
	end
endmodule : adcss_conv_model

// *** verif/test_adc_scan_sequencer.sv ***
// Self-checking bench of the scan sequencer with a behavioural converter.
// Assumes the design files and the converter model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module test_adc_scan_sequencer;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic single_req = 1'b0, start = 1'b0, sw_retrig = 1'b0, stop_ord = 1'b0, stop_abr = 1'b0;
	logic buf_full = 1'b0, init_ext = 1'b0, trig_en = 1'b0, slow = 1'b0, sclk_ext = 1'b0;
	logic ext_trig = 1'b0, ext_sclk = 1'b0, cgl_we = 1'b0, conv_done, flush, done, busy;
	logic [1:0] rt_src = 2'h0;
	logic [4:0] single_chan = 5'h00, cgl_data = 5'h00;
	logic [3:0] cgl_addr = 4'h0, cgl_last = 4'h2;
	logic [23:0] rt_div = 24'h000001, sclk_div = 24'h000008;
	logic [15:0] conv_data;
	adcss_pkg::adcss_conv_t conv;
	adcss_pkg::adcss_sample_t smp;
	logic [4:0] lst [3] = '{5'h05, 5'h0A, 5'h11};
	int n_mismatch = 0, compares = 0, n_flush = 0, n_done = 0, n_smp = 0;
	logic got;

	adcss_sequencer i_adcss_sequencer (.CLK(clk), .RESET_N(reset_n), .SINGLE_REQ(single_req),
		.SINGLE_CHAN(single_chan), .START(start), .SW_RETRIG(sw_retrig), .STOP_ORDERLY(stop_ord),
		.STOP_ABRUPT(stop_abr), .BUF_FULL(buf_full), .INIT_TRIG_EXT(init_ext),
		.TRIGGERED_EN(trig_en), .RETRIG_SRC(rt_src), .RETRIG_DIV(rt_div), .SLOW_VARIANT(slow),
		.SCLK_EXT_SEL(sclk_ext), .SCLK_DIV(sclk_div), .CGL_WE(cgl_we), .CGL_ADDR(cgl_addr),
		.CGL_DATA(cgl_data), .CGL_LAST(cgl_last), .EXT_TRIG(ext_trig), .EXT_SCLK(ext_sclk),
		.CONV(conv), .CONV_DONE(conv_done), .CONV_DATA(conv_data), .SAMPLE(smp), .FLUSH(flush),
		.DONE(done), .BUSY(busy));
	adcss_conv_model i_adcss_conv_model (.clk(clk), .reset_n(reset_n), .conv(conv),
		.done(conv_done), .data(conv_data));

	// Clock of 25 ns period.
	always #12.5 clk = ~clk;

	// Pulse counters, so one-cycle outputs are never missed between checks.
	always @(posedge clk) begin
		n_flush += int'(flush === 1'b1);
		n_done += int'(done === 1'b1);
		n_smp += int'(smp.valid === 1'b1);
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse

	task automatic wait_smp(input int lim, output logic g);
		g = 1'b0;
		repeat (lim) begin
			@(negedge clk);
			if (smp.valid === 1'b1) begin
				g = 1'b1;
				break;
			end
		end
	endtask : wait_smp

	// Each entry comes back in list order, tagged with its index and its channel's data.
	task automatic check_pass(input int n, input int e0);
		for (int i = 0; i < n; i++) begin
			wait_smp(80, got);
			`CHK(got, 1'b1)
			`CHK(smp.entry, 4'((e0 + i) % 3))
			`CHK(smp.data, {11'h2D3, lst[(e0 + i) % 3]})
		end
	endtask : check_pass

	task automatic stop_wait();
		int d0;
		d0 = n_done;
		pulse(stop_ord);
		repeat (60) begin
			@(negedge clk);
			if (busy === 1'b0) break;
		end
		`CHK(busy, 1'b0)
		// The pulse counter sees the done pulse one edge after it rises.
		@(negedge clk);
		`CHK(n_done - d0, 1)
	endtask : stop_wait

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_single();
		single_chan = 5'h03;
		`CHK(busy, 1'b0)
		pulse(single_req);
		`CHK(conv.start, 1'b1)
		`CHK(conv.chan, 5'h03)
		pulse(stop_abr);
		wait_smp(20, got);
		`CHK(got, 1'b1)
		`CHK(smp.data, 16'h5A63)
		`CHK(smp.single, 1'b1)
		`CHK(n_flush, 0)
		@(negedge clk);
		`CHK(busy, 1'b0)
		$display("single read done");
	endtask : t_single

	task automatic t_cont();
		for (int i = 0; i < 3; i++) begin
			@(negedge clk);
			cgl_we = 1'b1;
			cgl_addr = 4'(i);
			cgl_data = lst[i];
		end
		@(negedge clk);
		cgl_we = 1'b0;
		pulse(start);
		check_pass(5, 0);
		stop_wait();
		pulse(sw_retrig);
		repeat (40) @(negedge clk);
		`CHK(busy, 1'b0)
		$display("continuous scan done");
	endtask : t_cont

	task automatic t_sw();
		int f0;
		int s0;
		trig_en = 1'b1;
		pulse(start);
		check_pass(3, 0);
		wait_smp(100, got);
		`CHK(got, 1'b0)
		pulse(sw_retrig);
		check_pass(3, 0);
		pulse(sw_retrig);
		check_pass(1, 0);
		f0 = n_flush;
		pulse(stop_abr);
		repeat (2) @(negedge clk);
		`CHK(n_flush - f0, 1)
		`CHK(busy, 1'b0)
		s0 = n_smp;
		pulse(sw_retrig);
		repeat (80) @(negedge clk);
		`CHK(n_smp - s0, 0)
		$display("software retrigger done");
	endtask : t_sw

	task automatic t_ext();
		rt_src = 2'h1;
		init_ext = 1'b1;
		// The start command only arms the scan; the external edge is the trigger.
		pulse(start);
		pulse(ext_trig);
		check_pass(1, 0);
		pulse(ext_trig);
		check_pass(2, 1);
		wait_smp(100, got);
		`CHK(got, 1'b0)
		pulse(ext_trig);
		check_pass(3, 0);
		stop_wait();
		$display("external retrigger done");
	endtask : t_ext

	// A divider below the least interval is clamped to 120 base ticks, 400 system clocks,
	// or 240 ticks, 800 clocks, on the slower variant.
	// Even 10 us exceeds three entries at the 1.5 MHz sample clock plus 2 us.
	task automatic t_int();
		realtime t0;
		int gap;
		rt_src = 2'h2;
		init_ext = 1'b0;
		for (int v = 0; v < 2; v++) begin
			slow = 1'(v);
			pulse(start);
			check_pass(3, 0);
			t0 = $realtime;
			wait_smp(1000, got);
			gap = int'(($realtime - t0) / 25.0);
			`CHK(got, 1'b1)
			`CHK(smp.entry, 4'h0)
			`CHK(gap > 250 + 400 * v && gap < 420 + 400 * v, 1'b1)
			stop_wait();
		end
		$display("internal retrigger done");
	endtask : t_int

	// External sample clock paces each conversion; a full buffer ends the scan in order.
	task automatic t_eclk();
		int s0;
		int d0;
		sclk_ext = 1'b1;
		trig_en = 1'b0;
		s0 = n_smp;
		pulse(start);
		repeat (40) @(negedge clk);
		`CHK(n_smp - s0, 0)
		for (int i = 0; i < 2; i++) begin
			pulse(ext_sclk);
			check_pass(1, i);
		end
		d0 = n_done;
		@(negedge clk);
		buf_full = 1'b1;
		repeat (3) @(negedge clk);
		buf_full = 1'b0;
		`CHK(busy, 1'b0)
		`CHK(n_done - d0, 1)
		$display("external sample clock done");
	endtask : t_eclk

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	// Main sequence after five reset cycles.
	initial begin
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		t_single();
		t_cont();
		t_sw();
		t_ext();
		t_int();
		t_eclk();
		final_report();
	end

	// Watchdog well beyond the few thousand cycles the scenarios need.
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		final_report();
	end
endmodule : test_adc_scan_sequencer
